// ---- udw_regs.svh ----
// Purpose : constants for the up/down wiper host controller
// Assumes : 20 MHz mclk
// Notes   : timing counts derive from times in ns
`ifndef UDW_REGS_SVH
`define UDW_REGS_SVH
`define UDW_CLK_NS        50
`define UDW_SETUP_NS      500
`define UDW_HALF_NS       500
`define UDW_SETUP_CYC     ((`UDW_SETUP_NS + `UDW_CLK_NS - 1) / `UDW_CLK_NS)
`define UDW_HALF_CYC      ((`UDW_HALF_NS + `UDW_CLK_NS - 1) / `UDW_CLK_NS)
`define UDW_WIPER_DEFAULT 6'h1F
`define UDW_WIPER_MAX     6'h3F
`define UDW_WIPER_MIN     6'h00
`define UDW_CNT_W         8
`endif

// ---- udw_pkg.sv ----
// Purpose : shared types for the up/down wiper host controller
// Assumes : nothing
// Notes   : command codes select one of the eight device commands
package udw_pkg;
  typedef enum logic [2:0] {
    UDW_CMD_INC,
    UDW_CMD_INC_COMPAT,
    UDW_CMD_DEC,
    UDW_CMD_DEC_COMPAT,
    UDW_CMD_HV_INC1,
    UDW_CMD_HV_INC2,
    UDW_CMD_HV_DEC1,
    UDW_CMD_HV_DEC2
  } udw_cmd_t;
endpackage

// ---- udw_tick.sv ----
// Purpose : one-cycle enable pulse every DIV mclk cycles
// Assumes : DIV at least 1
// Notes   : runs only while en is high, restarts when en drops
`timescale 1ns/100ps
module udw_tick #(
  parameter int W   = 8,
  parameter int DIV = 10
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      tick
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (!en)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_r == W'(DIV - 1))
    begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- udw_host.sv ----
// Purpose : host that drives chip select and up/down of a 6-bit wiper pot
// Assumes : pin levels are made by external drivers from the select outputs
// Notes   : tracks a shadow of the wiper, since the device is write-only
`timescale 1ns/100ps
`include "udw_regs.svh"
module udw_host #(
  parameter int CNT_W = `UDW_CNT_W,
  parameter int SETUP = `UDW_SETUP_CYC,
  parameter int HALF  = `UDW_HALF_CYC
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            cmd_valid,
  input  wire udw_pkg::udw_cmd_t cmd,
  input  wire logic [5:0]      steps,
  input  wire logic            dev_reset,
  output logic                 cmd_ready,
  output logic                 select_low,
  output logic                 select_elevated,
  output logic                 updown,
  output logic [5:0]           wiper_shadow,
  output logic                 done
);
  import udw_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // dev_reset comes from supply monitoring, outside this clock
  logic dr_s1_r;
  logic dr_s2_r;

  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      dr_s1_r <= 1'b0;
      dr_s2_r <= 1'b0;
    end
    else
    begin
      dr_s1_r <= dev_reset;
      dr_s2_r <= dr_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETDIR, ST_SELECT, ST_LOW, ST_HIGH, ST_ENDDIR, ST_RELEASE
  } udw_state_t;

  udw_state_t   state_r;
  udw_cmd_t     cmd_r;
  logic [5:0]   left_r;
  logic         tick;
  logic         up_dir;
  logic         hv;
  logic         end_level;

  assign up_dir = (cmd_r == UDW_CMD_INC) || (cmd_r == UDW_CMD_INC_COMPAT) ||
                  (cmd_r == UDW_CMD_HV_INC1) || (cmd_r == UDW_CMD_HV_INC2);
  assign hv     = (cmd_r == UDW_CMD_HV_INC1) || (cmd_r == UDW_CMD_HV_INC2) ||
                  (cmd_r == UDW_CMD_HV_DEC1) || (cmd_r == UDW_CMD_HV_DEC2);

  // up/down level held while select returns to normal high
  always_comb
  begin
    case (cmd_r)
      UDW_CMD_HV_INC1:    end_level = 1'b1;
      UDW_CMD_HV_INC2:    end_level = 1'b0;
      UDW_CMD_HV_DEC1:    end_level = 1'b0;
      UDW_CMD_INC_COMPAT: end_level = 1'b0;
      UDW_CMD_DEC:        end_level = 1'b0;
      UDW_CMD_DEC_COMPAT: end_level = 1'b1;
      UDW_CMD_HV_DEC2:    end_level = 1'b1;
      default:            end_level = 1'b0;
    endcase
  end

  // one divider paces every phase; the longer of the two counts wins
  // so direction setup is never cut short
  udw_tick #(
    .W   (CNT_W),
    .DIV ((HALF > SETUP) ? HALF : SETUP)
  ) u_tick (
    .mclk  (mclk),
    .rst_n (rst_s2_r),
    .en    (state_r != ST_IDLE),
    .tick  (tick)
  );

  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      state_r <= ST_IDLE;
      cmd_r   <= UDW_CMD_INC;
      left_r  <= 6'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (cmd_valid && !dr_s2_r)
          begin
            cmd_r   <= cmd;
            left_r  <= steps;
            state_r <= ST_SETDIR;
          end
        ST_SETDIR:
          if (tick)
            state_r <= ST_SELECT;
        ST_SELECT:
          if (tick)
            state_r <= (left_r == 6'h00) ? ST_ENDDIR : ST_LOW;
        ST_LOW:
          if (tick)
            state_r <= ST_HIGH;
        ST_HIGH:
          if (tick)
          begin
            left_r  <= left_r - 1'b1;
            state_r <= (left_r == 6'h01) ? ST_ENDDIR : ST_LOW;
          end
        ST_ENDDIR:
          if (tick)
            state_r <= ST_RELEASE;
        ST_RELEASE:
          if (tick)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      select_low      <= 1'b0;
      select_elevated <= 1'b0;
      updown          <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_SETDIR:
        begin
          updown <= up_dir;
          if (tick)
          begin
            select_low      <= !hv;
            select_elevated <= hv;
          end
        end
        ST_LOW:
          if (tick)
            updown <= 1'b1;
        // a high end level stays up after the last step: dropping and
        // raising it again while selected would be one step too many
        ST_HIGH:
          if (tick)
            updown <= (left_r == 6'h01) ? end_level : 1'b0;
        ST_SELECT:
          if (tick && left_r != 6'h00)
            updown <= 1'b0;
        // may fall but never rise here; limitation: after zero steps a low
        // start cannot reach a high end level without stepping the wiper
        ST_ENDDIR:
        begin
          updown <= updown & end_level;
          if (tick)
          begin
            select_low      <= 1'b0;
            select_elevated <= 1'b0;
          end
        end
        default:
        begin
          select_low      <= 1'b0;
          select_elevated <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shadow wiper and status
  // ----------------------------------------------------------------
  // device cannot be read back, so the host mirrors its arithmetic
  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      wiper_shadow <= `UDW_WIPER_DEFAULT;
    else if (dr_s2_r)
      wiper_shadow <= `UDW_WIPER_DEFAULT;
    else if (state_r == ST_LOW && tick)
    begin
      if (up_dir && wiper_shadow != `UDW_WIPER_MAX)
        wiper_shadow <= wiper_shadow + 1'b1;
      else if (!up_dir && wiper_shadow != `UDW_WIPER_MIN)
        wiper_shadow <= wiper_shadow - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      cmd_ready <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      cmd_ready <= (state_r == ST_IDLE) && !cmd_valid && !dr_s2_r;
      done      <= (state_r == ST_RELEASE) && tick;
    end
  end
endmodule

// ---- udw_host_monitor.sv ----
// Purpose: pin checks on udw_host
// Assumes: one clock domain
// Notes: direction is left to the model
`timescale 1ns/100ps
module udw_mon (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       select_low,
  input wire logic       select_elevated,
  input wire logic       updown,
  input wire logic [5:0] wiper_shadow,
  input wire logic       done
);
  wire sel = select_low | select_elevated;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_lvl; !(select_low && select_elevated); endproperty
  a_lvl: assert property (p_lvl) else $error("two levels");
  property p_dir; $rose(sel) |-> $stable(updown); endproperty
  a_dir: assert property (p_dir) else $error("dir moved");
  property p_stp; $rose(updown) && sel && $past(wiper_shadow) != 6'h3F
    && $past(wiper_shadow) != 6'h00 |-> $changed(wiper_shadow); endproperty
  a_stp: assert property (p_stp) else $error("no step");
  property p_end; $rose(updown) && sel |-> ##[1:40] (!updown || !sel);
  endproperty
  a_end: assert property (p_end) else $error("late end");
  property p_rel; $fell(sel) |-> ##[1:40] done; endproperty
  a_rel: assert property (p_rel) else $error("no done");
  property p_dn; done |-> !sel ##1 !done; endproperty
  a_dn: assert property (p_dn) else $error("bad done");
  property p_hold; $fell(sel) |-> $stable(updown); endproperty
  a_hold: assert property (p_hold) else $error("end level moved");
  c_hv: cover property ($rose(select_elevated));
  c_lo: cover property ($rose(select_low));
  c_dn: cover property (done);
endmodule
bind udw_host udw_mon udw_mon_i (.mclk(mclk), .rst_n(rst_n),
  .select_low(select_low), .select_elevated(select_elevated),
  .updown(updown), .wiper_shadow(wiper_shadow), .done(done));

// ---- udw_pot.sv ----
// Purpose: behavioural up/down wiper device
// Assumes: pins sampled on mclk
// Notes: dev_reset stands for power-up and brown-out
`timescale 1ns/100ps
module udw_pot (
  input wire logic       mclk,
  input wire logic       select_low,
  input wire logic       select_elevated,
  input wire logic       updown,
  input wire logic       dev_reset,
  output logic     [5:0] wiper
);
  logic [1:0] s_q, u_q;
  logic u_d, act, dir;
  always @(posedge mclk or posedge dev_reset)
    if (dev_reset)
      wiper <= 6'h1F;
    else
    begin
      s_q <= {s_q[0], select_low | select_elevated};
      u_q <= {u_q[0], updown};
      u_d <= u_q[1];
      if (!s_q[1])
        act <= 1'h0;
      else if (!act)
      begin
        act <= 1'h1;
        dir <= u_q[1];
      end
      else if (u_q[1] && !u_d)
        wiper <= dir ? wiper + (wiper != 6'h3F)
                     : wiper - (wiper != 6'h00);
    end
endmodule

// ---- udw_host_tb.sv ----
// Purpose: self-checking bench for udw_host
// Assumes: SETUP and HALF shortened to 2
// Notes: model udw_pot stands on the pins
`timescale 1ns/100ps
module udw_host_tb;
  import udw_pkg::*;
  typedef struct {udw_cmd_t c; logic [5:0] n; logic d, e;} udw_row_t;
  // command, steps, direction, end level
  udw_row_t rows [8] = '{'{UDW_CMD_INC, 6'h03, 1'h1, 1'h0},
    '{UDW_CMD_INC_COMPAT, 6'h02, 1'h1, 1'h0},
    '{UDW_CMD_DEC, 6'h05, 1'h0, 1'h0},
    '{UDW_CMD_DEC_COMPAT, 6'h01, 1'h0, 1'h1},
    '{UDW_CMD_HV_INC1, 6'h02, 1'h1, 1'h1},
    '{UDW_CMD_HV_INC2, 6'h01, 1'h1, 1'h0},
    '{UDW_CMD_HV_DEC1, 6'h04, 1'h0, 1'h0},
    '{UDW_CMD_HV_DEC2, 6'h02, 1'h0, 1'h1}};
  logic       mclk, rst_n, cmd_valid, dev_reset, cmd_ready, select_low;
  logic       select_elevated, updown, done, lvl, hv;
  udw_cmd_t   cmd;
  logic [5:0] steps, wiper_shadow, wiper, exp_w;
  int         miscompares, checks_done;
  always #25 mclk = ~mclk;
  udw_host #(.SETUP(2), .HALF(2)) udw_host_i (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .steps(steps),
    .dev_reset(dev_reset), .cmd_ready(cmd_ready),
    .select_low(select_low), .select_elevated(select_elevated),
    .updown(updown), .wiper_shadow(wiper_shadow), .done(done));
  udw_pot udw_pot_i (.mclk(mclk), .select_low(select_low),
    .select_elevated(select_elevated), .updown(updown),
    .dev_reset(dev_reset), .wiper(wiper));
  task automatic chk(string nm, logic [5:0] ex, logic [5:0] sn);
    checks_done++;
    if (sn !== ex)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, ex, sn);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one cycle; a hang runs the count out
  task automatic tick(inout int k);
    @(posedge mclk);
    #1;
    k++;
    if (k > 2000)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic run(udw_cmd_t c, logic [5:0] n, logic d);
    int k;
    logic p;
    k = 0;
    p = 1'h0;
    hv = 1'h0;
    while (cmd_ready !== 1'h1)
      tick(k);
    cmd = c;
    steps = n;
    cmd_valid = 1'h1;
    tick(k);
    cmd_valid = 1'h0;
    while (done !== 1'h1)
    begin
      tick(k);
      if (p && (select_low | select_elevated) === 1'h0)
        lvl = updown;
      p = select_low | select_elevated;
      hv = hv | select_elevated;
    end
    exp_w = d ? (exp_w + n > 63 ? 6'h3F : exp_w + n)
              : (exp_w < n ? 6'h00 : exp_w - n);
  endtask
  initial
  begin
    mclk = 1'h0;
    rst_n = 1'h0;
    dev_reset = 1'h1;
    cmd_valid = 1'h0;
    cmd = UDW_CMD_INC;
    steps = 6'h00;
    exp_w = 6'h1F;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    dev_reset = 1'h0;
    chk("shadow", 6'h1F, wiper_shadow);
    chk("wiper", 6'h1F, wiper);
    foreach (rows[i])
    begin
      run(rows[i].c, rows[i].n, rows[i].d);
      chk("end", {5'h00, rows[i].e}, {5'h00, lvl});
      chk("hv", {5'h00, rows[i].c[2]}, {5'h00, hv});
      chk("wiper", exp_w, wiper);
      chk("shadow", exp_w, wiper_shadow);
    end
    run(UDW_CMD_INC, 6'h3F, 1'h1);
    chk("top", 6'h3F, wiper);
    run(UDW_CMD_DEC, 6'h3F, 1'h0);
    chk("bottom", 6'h00, wiper);
    dev_reset = 1'h1;
    repeat (4) @(posedge mclk);
    #1;
    dev_reset = 1'h0;
    exp_w = 6'h1F;
    chk("reload", exp_w, wiper);
    chk("reload shadow", exp_w, wiper_shadow);
    run(UDW_CMD_DEC_COMPAT, 6'h01, 1'h0);
    chk("after reload", exp_w, wiper);
    run(UDW_CMD_HV_INC1, 6'h00, 1'h1);
    chk("zero end", 6'h01, {5'h00, lvl});
    chk("zero", exp_w, wiper);
    end_sim();
  end
endmodule
